/* File: src/cdpmc_pkg.sv */
// Package: constants and types of the clock divide / power mode controller
// What this block does
// - Compatibility option halves CPU clock at divider zero: machine cycle 12 oscillator clocks, not 6.
// - Divider zero: CPU clock is oscillator rate, or half with compatibility option.
// - Divider value N 1..255 divides CPU clock by 2*(N+1), ratios 4..512.
// - Divider may be rewritten anytime; new ratio adopted without halting execution.
// - Brownout resets by default; interrupt-select bit 5 of auxiliary register interrupts instead.
// - Threshold 2.5 V when level bit is one, 3.8 V when zero.
// - Reset mode holds processor in reset while brownout detector stays active.
// - Interrupt mode raises request once on falling through; needs both enables.
// - Any brownout activation sets brownout flag, kept until software clears it.
// - Brownout flag also set at power-on; software clears it writing zero.
// - Brownout-disable bit 6 turns detection off: no reset, no interrupt.
// - Power-up detection sets power-on flag, kept until software clears it.
// - Idle bit stops CPU, peripherals run; interrupt or reset ends idle, bit cleared.
// - Power-down bit stops oscillator; bit cleared when power-down ends.
// - Power-down ends on reset or enabled wake interrupt of higher priority.
// - On wake restart oscillator, hold execution 1024 clocks crystal, 256 otherwise.
// - In power-down brownout reset resets at once; brownout interrupt wakes instead.
// - Running watchdog may reset the processor during power-down.
// - Two general-purpose bits are read/write and have no hardware effect.
// - Serial-bit-select picks meaning of serial control bit 7: mode bit or framing error.
package cdpmc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] POWER_CONTROL_IDX = 10'h087;
  localparam logic [9:0] CPU_CLOCK_DIVIDER_IDX = 10'h095;
  localparam logic [9:0] SERIAL_CONTROL_IDX = 10'h098;
  localparam logic [9:0] AUX_IDX = 10'h0a2;
  localparam logic [9:0] STAT_IDX = 10'h0f0;
  // power_control fields
  localparam int POWER_CONTROL_IDL = 0;
  localparam int POWER_CONTROL_PD = 1;
  localparam int POWER_CONTROL_GF0 = 2;
  localparam int POWER_CONTROL_GF1 = 3;
  localparam int POWER_CONTROL_POF = 4;
  localparam int POWER_CONTROL_BOF = 5;
  localparam int POWER_CONTROL_SBS = 6;
  localparam int POWER_CONTROL_BAUD = 7;
  localparam logic [7:0] POWER_CONTROL_POR_VAL = 8'h30;
  // auxiliary_control fields and serial control bit 7
  localparam int AUX_BOI = 5;
  localparam int AUX_BOD = 6;
  localparam int SERIAL_CONTROL_B7 = 7;
  // Timing counts
  localparam int MCYCLE_CLKS = 6;
  localparam int STARTUP_XTAL = 1024;
  localparam int STARTUP_RC = 256;
  localparam int DIV_W = 10;
  typedef enum logic [1:0] {MODE_RUN, MODE_IDLE, MODE_PDOWN, MODE_WAKE} cdpmc_mode_t;
endpackage

/* File: src/cdpmc_clkdiv.sv */
// Glitch-free programmable clock-enable divider
`timescale 1ns/1ps
`default_nettype none
module cdpmc_clkdiv #(
  parameter int W = 10
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Ratio and tick
  input wire logic [W-1:0] ratio_i,
  output logic tick_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic [W-1:0] ratio;
    logic tick;
  } cdpmc_div_t;
  cdpmc_div_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt <= {{(W-1){1'b0}}, 1'b1}) begin
      // New ratio taken only at the period end, never mid-period
      st_next.ratio = ratio_i;
      st_next.cnt = ratio_i;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt - {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_o = st_reg.tick;

  // Helper: cycles since last tick
  logic [W:0] gap;
  logic seen;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap <= '0;
      seen <= 1'b0;
    end else if (tick_o) begin
      gap <= {{W{1'b0}}, 1'b1};
      seen <= 1'b1;
    end else begin
      gap <= gap + {{W{1'b0}}, 1'b1};
    end
  end

  tick_spacing_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tick_o && seen && st_reg.ratio > 1 |-> gap == {1'b0, $past(st_reg.ratio)})
    else $error("tick spacing differs from adopted ratio");
endmodule
`default_nettype wire

/* File: src/cdpmc_startup.sv */
// Oscillator start-up counter held after power-down wake
`timescale 1ns/1ps
`default_nettype none
module cdpmc_startup #(
  parameter int LONG_CNT = cdpmc_pkg::STARTUP_XTAL,
  parameter int SHORT_CNT = cdpmc_pkg::STARTUP_RC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic start_i,
  input wire logic long_i,
  output logic busy_o,
  output logic done_o
);
  typedef struct packed {
    logic [10:0] cnt;
    logic busy;
    logic done;
  } cdpmc_su_t;
  cdpmc_su_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (start_i) begin
      st_next.busy = 1'b1;
      st_next.cnt = long_i ? 11'(LONG_CNT - 1) : 11'(SHORT_CNT - 1);
    end else if (st_reg.busy) begin
      if (st_reg.cnt == 11'h000) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt - 11'h001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy_o = st_reg.busy;
  assign done_o = st_reg.done;

  // Helper: clocks counted since start
  logic [11:0] el;
  logic was_long;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      el <= '0;
      was_long <= 1'b0;
    end else if (start_i) begin
      el <= 12'h000;
      was_long <= long_i;
    end else if (st_reg.busy) begin
      el <= el + 12'h001;
    end
  end

  sequence s_begin;
    start_i;
  endsequence
  sequence s_hold;
    busy_o [*8];
  endsequence

  start_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_begin |=> s_hold)
    else $error("start-up released too early");
  startup_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    done_o |-> el == (was_long ? 12'(LONG_CNT) : 12'(SHORT_CNT)))
    else $error("start-up count length wrong");
endmodule
`default_nettype wire

/* File: src/cdpmc_ctrl.sv */
// Top: CPU clock divider, brownout and power mode control with APB registers
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module cdpmc_ctrl #(
  parameter int AW = 12,
  parameter int STARTUP_LONG = cdpmc_pkg::STARTUP_XTAL,
  parameter int STARTUP_SHORT = cdpmc_pkg::STARTUP_RC
) (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [AW-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Configuration bits
  input wire logic COMPAT_HALVE_I,
  input wire logic BOV_CFG_I,
  input wire logic OSC_CRYSTAL_I,
  // Detectors and reset sources
  input wire logic POWER_ON_I,
  input wire logic BO_DET_I,
  input wire logic WDT_RESET_I,
  input wire logic EXT_RESET_I,
  // Interrupt controller
  input wire logic GIE_I,
  input wire logic BO_IE_I,
  input wire logic BO_IRQ_ACK_I,
  input wire logic IRQ_PENDING_I,
  input wire logic WAKE_IRQ_I,
  output logic BROWNOUT_IRQ_O,
  // UART side
  input wire logic FRAMING_ERR_I,
  output logic BAUD_DOUBLE_O,
  output logic SERIAL_BIT_SELECT_O,
  output logic SERIAL_MODE_BIT_O,
  // Clocking and power outputs
  output logic CPU_CLK_EN_O,
  output logic PERIPH_CLK_EN_O,
  output logic MCYCLE_EN_O,
  output logic OSC_RUN_O,
  output logic CPU_RESET_O,
  output logic BO_LEVEL_HIGH_O,
  output logic IDLE_O,
  output logic PDOWN_O
);
  typedef struct packed {
    logic [7:0] power_control;
    logic [7:0] cpu_clock_divider;
    logic brownout_irq_select;
    logic brownout_disable;
    logic sm0;
    cdpmc_pkg::cdpmc_mode_t mode;
    logic bo_q;
    logic bo_irq;
    logic cpu_rst;
    logic lvl_high;
    logic [2:0] mcnt;
    logic [31:0] prdata;
  } cdpmc_st_t;
  cdpmc_st_t st_reg, st_next;

  logic [cdpmc_pkg::DIV_W-1:0] ratio;
  logic tick;
  logic su_start;
  logic su_busy;
  logic su_done;
  logic bo_on;
  logic bo_fall;
  logic bo_rst;
  logic bo_wake;
  logic rst_src;
  logic wake;
  logic setup;
  logic access;
  logic wr;
  logic [9:0] idx;
  logic mapped;
  logic run_periph;

  // Ratio from divider and compatibility option
  always_comb begin
    if (st_reg.cpu_clock_divider == 8'h00) begin
      ratio = COMPAT_HALVE_I ? 10'h002 : 10'h001;
    end else begin
      ratio = {1'b0, st_reg.cpu_clock_divider, 1'b0} + 10'h002;
    end
  end

  cdpmc_clkdiv #(
    .W(cdpmc_pkg::DIV_W)
  ) u_div (
    .clk_i(CLOCK_I),
    .rst_i(SYS_RST_I),
    .ratio_i(ratio),
    .tick_o(tick)
  );

  // Brownout detection terms
  assign bo_on = BO_DET_I & ~st_reg.brownout_disable;
  assign bo_fall = bo_on & ~st_reg.bo_q;
  assign bo_rst = bo_on & ~st_reg.brownout_irq_select;
  assign bo_wake = st_reg.bo_irq & GIE_I & BO_IE_I;
  assign rst_src = bo_rst | WDT_RESET_I | EXT_RESET_I;
  assign wake = WAKE_IRQ_I | bo_wake;
  assign su_start = (st_reg.mode == cdpmc_pkg::MODE_PDOWN) & (wake | rst_src);

  cdpmc_startup #(
    .LONG_CNT(STARTUP_LONG),
    .SHORT_CNT(STARTUP_SHORT)
  ) u_su (
    .clk_i(CLOCK_I),
    .rst_i(SYS_RST_I),
    .start_i(su_start),
    .long_i(OSC_CRYSTAL_I),
    .busy_o(su_busy),
    .done_o(su_done)
  );

  // APB decode
  assign setup = PSEL_I & ~PENABLE_I;
  assign access = PSEL_I & PENABLE_I;
  assign idx = PADDR_I[11:2];
  assign mapped = (PADDR_I[1:0] == 2'b00) &&
    (idx == cdpmc_pkg::POWER_CONTROL_IDX || idx == cdpmc_pkg::CPU_CLOCK_DIVIDER_IDX ||
     idx == cdpmc_pkg::SERIAL_CONTROL_IDX || idx == cdpmc_pkg::AUX_IDX ||
     idx == cdpmc_pkg::STAT_IDX);
  assign wr = access & PWRITE_I & mapped;

  always_comb begin
    st_next = st_reg;
    st_next.bo_q = bo_on;
    st_next.cpu_rst = rst_src;
    st_next.lvl_high = ~BOV_CFG_I;
    // Read data sampled in the setup cycle, shown in the access cycle
    if (setup & ~PWRITE_I) begin
      st_next.prdata = 32'h0000_0000;
      // Unmapped or misaligned reads return zero, never a register alias
      case (mapped ? idx : 10'h000)
        cdpmc_pkg::POWER_CONTROL_IDX: st_next.prdata[7:0] = st_reg.power_control;
        cdpmc_pkg::CPU_CLOCK_DIVIDER_IDX: st_next.prdata[7:0] = st_reg.cpu_clock_divider;
        cdpmc_pkg::SERIAL_CONTROL_IDX: begin
          st_next.prdata[cdpmc_pkg::SERIAL_CONTROL_B7] = st_reg.power_control[cdpmc_pkg::POWER_CONTROL_SBS] ?
            FRAMING_ERR_I : st_reg.sm0;
        end
        cdpmc_pkg::AUX_IDX: begin
          st_next.prdata[cdpmc_pkg::AUX_BOI] = st_reg.brownout_irq_select;
          st_next.prdata[cdpmc_pkg::AUX_BOD] = st_reg.brownout_disable;
        end
        cdpmc_pkg::STAT_IDX: begin
          st_next.prdata[1:0] = st_reg.mode;
          st_next.prdata[2] = BO_DET_I;
          st_next.prdata[3] = su_busy;
          st_next.prdata[4] = st_reg.bo_irq;
        end
        default: st_next.prdata = 32'h0000_0000;
      endcase
    end
    // Software writes
    if (wr) begin
      case (idx)
        cdpmc_pkg::POWER_CONTROL_IDX: st_next.power_control = PWDATA_I[7:0];
        cdpmc_pkg::CPU_CLOCK_DIVIDER_IDX: st_next.cpu_clock_divider = PWDATA_I[7:0];
        cdpmc_pkg::SERIAL_CONTROL_IDX: begin
          if (!st_reg.power_control[cdpmc_pkg::POWER_CONTROL_SBS]) begin
            st_next.sm0 = PWDATA_I[cdpmc_pkg::SERIAL_CONTROL_B7];
          end
        end
        cdpmc_pkg::AUX_IDX: begin
          st_next.brownout_irq_select = PWDATA_I[cdpmc_pkg::AUX_BOI];
          st_next.brownout_disable = PWDATA_I[cdpmc_pkg::AUX_BOD];
        end
        default: st_next.cpu_clock_divider = st_next.cpu_clock_divider;
      endcase
    end
    if (BO_IRQ_ACK_I) begin
      st_next.bo_irq = 1'b0;
    end
    // Power mode sequencing
    case (st_reg.mode)
      cdpmc_pkg::MODE_RUN: begin
        // Power-down wins when both bits are written together
        if (wr && idx == cdpmc_pkg::POWER_CONTROL_IDX && PWDATA_I[cdpmc_pkg::POWER_CONTROL_PD]) begin
          st_next.mode = cdpmc_pkg::MODE_PDOWN;
        end else if (wr && idx == cdpmc_pkg::POWER_CONTROL_IDX && PWDATA_I[cdpmc_pkg::POWER_CONTROL_IDL]) begin
          st_next.mode = cdpmc_pkg::MODE_IDLE;
        end
      end
      cdpmc_pkg::MODE_IDLE: begin
        if (IRQ_PENDING_I) begin
          st_next.mode = cdpmc_pkg::MODE_RUN;
          st_next.power_control[cdpmc_pkg::POWER_CONTROL_IDL] = 1'b0;
        end
      end
      cdpmc_pkg::MODE_PDOWN: begin
        if (wake) begin
          st_next.mode = cdpmc_pkg::MODE_WAKE;
        end
      end
      cdpmc_pkg::MODE_WAKE: begin
        if (su_done) begin
          st_next.mode = cdpmc_pkg::MODE_RUN;
          st_next.power_control[cdpmc_pkg::POWER_CONTROL_PD] = 1'b0;
          st_next.power_control[cdpmc_pkg::POWER_CONTROL_IDL] = 1'b0;
        end
      end
      default: st_next.mode = cdpmc_pkg::MODE_RUN;
    endcase
    // Any reset source clears the register state apart from the flags and, in power-down or wake, the PD bit
    if (rst_src) begin
      st_next.power_control = st_reg.power_control & 8'h30;
      st_next.cpu_clock_divider = 8'h00;
      st_next.sm0 = 1'b0;
      st_next.brownout_irq_select = 1'b0;
      st_next.brownout_disable = 1'b0;
      st_next.power_control[cdpmc_pkg::POWER_CONTROL_PD] = (st_reg.mode == cdpmc_pkg::MODE_PDOWN) ||
        (st_reg.mode == cdpmc_pkg::MODE_WAKE);
      if (st_reg.mode == cdpmc_pkg::MODE_PDOWN) begin
        st_next.mode = cdpmc_pkg::MODE_WAKE;
      end else if (st_reg.mode == cdpmc_pkg::MODE_IDLE) begin
        st_next.mode = cdpmc_pkg::MODE_RUN;
      end
    end
    // Hardware sets come last so they win over a clear in the same cycle
    if (bo_fall) begin
      st_next.power_control[cdpmc_pkg::POWER_CONTROL_BOF] = 1'b1;
      if (st_reg.brownout_irq_select) begin
        st_next.bo_irq = 1'b1;
      end
    end
    if (POWER_ON_I) begin
      st_next.power_control[cdpmc_pkg::POWER_CONTROL_POF] = 1'b1;
      st_next.power_control[cdpmc_pkg::POWER_CONTROL_BOF] = 1'b1;
    end
    // Machine cycle prescaler on peripheral ticks
    if (run_periph) begin
      if (st_reg.mcnt == 3'(cdpmc_pkg::MCYCLE_CLKS - 1)) begin
        st_next.mcnt = 3'h0;
      end else begin
        st_next.mcnt = st_reg.mcnt + 3'h1;
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      st_reg <= '0;
      st_reg.power_control <= cdpmc_pkg::POWER_CONTROL_POR_VAL;
      st_reg.cpu_rst <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Oscillator stops only in power-down; CPU stops in idle too
  assign run_periph = tick & ((st_reg.mode == cdpmc_pkg::MODE_RUN) ||
    (st_reg.mode == cdpmc_pkg::MODE_IDLE));
  assign CPU_CLK_EN_O = tick & (st_reg.mode == cdpmc_pkg::MODE_RUN);
  assign PERIPH_CLK_EN_O = run_periph;
  assign MCYCLE_EN_O = run_periph && st_reg.mcnt == 3'(cdpmc_pkg::MCYCLE_CLKS - 1);
  assign OSC_RUN_O = st_reg.mode != cdpmc_pkg::MODE_PDOWN;
  assign CPU_RESET_O = st_reg.cpu_rst;
  assign BROWNOUT_IRQ_O = bo_wake;
  assign BO_LEVEL_HIGH_O = st_reg.lvl_high;
  assign BAUD_DOUBLE_O = st_reg.power_control[cdpmc_pkg::POWER_CONTROL_BAUD];
  assign SERIAL_BIT_SELECT_O = st_reg.power_control[cdpmc_pkg::POWER_CONTROL_SBS];
  assign SERIAL_MODE_BIT_O = st_reg.sm0;
  assign IDLE_O = st_reg.mode == cdpmc_pkg::MODE_IDLE;
  assign PDOWN_O = st_reg.mode == cdpmc_pkg::MODE_PDOWN;
  assign PRDATA_O = st_reg.prdata;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = access & ~mapped;

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (SYS_RST_I);

  bo_reset_hold_a: assert property (
    BO_DET_I && !st_reg.brownout_disable && !st_reg.brownout_irq_select |=> CPU_RESET_O)
    else $error("brownout did not hold reset");
  bo_disable_a: assert property (
    st_reg.brownout_disable && !WDT_RESET_I && !EXT_RESET_I |=> !CPU_RESET_O && !$rose(st_reg.bo_irq))
    else $error("disabled brownout still acted");
  bo_flag_set_a: assert property (
    bo_fall |=> st_reg.power_control[cdpmc_pkg::POWER_CONTROL_BOF])
    else $error("brownout flag not set");
  bo_irq_once_a: assert property (
    $rose(st_reg.bo_irq) |-> $past(bo_fall) && $past(st_reg.brownout_irq_select))
    else $error("brownout request without falling edge");
  power_on_flags_a: assert property (
    POWER_ON_I |=> st_reg.power_control[cdpmc_pkg::POWER_CONTROL_POF] && st_reg.power_control[cdpmc_pkg::POWER_CONTROL_BOF])
    else $error("power-on flags not set");
  idle_exit_a: assert property (
    IDLE_O && IRQ_PENDING_I |=> !IDLE_O && !st_reg.power_control[cdpmc_pkg::POWER_CONTROL_IDL])
    else $error("idle not ended by interrupt");
  pdown_osc_a: assert property (
    PDOWN_O |-> !OSC_RUN_O && !CPU_CLK_EN_O && !PERIPH_CLK_EN_O)
    else $error("clock active in power-down");
  wake_start_a: assert property (
    PDOWN_O && WAKE_IRQ_I |=> OSC_RUN_O && su_busy && !CPU_CLK_EN_O)
    else $error("wake did not restart oscillator");
  wake_end_a: assert property (
    su_done && st_reg.mode == cdpmc_pkg::MODE_WAKE && !rst_src |=>
      st_reg.mode == cdpmc_pkg::MODE_RUN && !st_reg.power_control[cdpmc_pkg::POWER_CONTROL_PD])
    else $error("execution not resumed after start-up");
endmodule
`default_nettype wire

/* File: tb/cdpmc_cpu_model.sv */
// Behavioural CPU core and interrupt controller facing the block
`timescale 1ns/1ps
`default_nettype none
module cdpmc_cpu_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench control
  input wire logic en_i,
  input wire logic [7:0] ack_wait_i,
  // Block side
  input wire logic bo_irq_i,
  output logic gie_o,
  output logic bo_ie_o,
  output logic ack_o
);
  logic [7:0] cnt;
  // Software sets both enables together
  assign gie_o = en_i;
  assign bo_ie_o = en_i;
  // Service latency is programmable so slow handlers are exercised
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 8'h00;
      ack_o <= 1'b0;
    end else if (bo_irq_i && !ack_o && cnt == ack_wait_i) begin
      cnt <= 8'h00;
      ack_o <= 1'b1;
    end else begin
      cnt <= (bo_irq_i && !ack_o) ? cnt + 8'h01 : 8'h00;
      ack_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench of the clock divide and power mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int LONG = 16;
  localparam int SHORT = 8;
  localparam logic [11:0] A_POWER_CONTROL = {cdpmc_pkg::POWER_CONTROL_IDX, 2'b00};
  localparam logic [11:0] A_CPU_CLOCK_DIVIDER = {cdpmc_pkg::CPU_CLOCK_DIVIDER_IDX, 2'b00};
  localparam logic [11:0] A_SERIAL_CONTROL = {cdpmc_pkg::SERIAL_CONTROL_IDX, 2'b00};
  localparam logic [11:0] A_AUX = {cdpmc_pkg::AUX_IDX, 2'b00};
  logic clk, rst, psel, pen, pwr, compat, brownout_level_select, xtal, pwron, bodet, wdt, pend, wake, en, mc, er;
  logic pready, pslverr, gie, boie, ack, boirq, baud, sbs, smode, cpuen, peren, mcyc;
  logic osc, cpurst, lvl, idle, pdn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] ackw;
  int err_total, samples_checked, n;
  wire logic probe;
  assign probe = mc ? mcyc : cpuen;

  cdpmc_ctrl #(.AW(12), .STARTUP_LONG(LONG), .STARTUP_SHORT(SHORT)) i_dut (
    .CLOCK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .COMPAT_HALVE_I(compat), .BOV_CFG_I(brownout_level_select), .OSC_CRYSTAL_I(xtal),
    .POWER_ON_I(pwron), .BO_DET_I(bodet), .WDT_RESET_I(wdt), .EXT_RESET_I(1'b0),
    .GIE_I(gie), .BO_IE_I(boie), .BO_IRQ_ACK_I(ack), .IRQ_PENDING_I(pend),
    .WAKE_IRQ_I(wake), .BROWNOUT_IRQ_O(boirq), .FRAMING_ERR_I(1'b0),
    .BAUD_DOUBLE_O(baud), .SERIAL_BIT_SELECT_O(sbs), .SERIAL_MODE_BIT_O(smode),
    .CPU_CLK_EN_O(cpuen), .PERIPH_CLK_EN_O(peren), .MCYCLE_EN_O(mcyc), .OSC_RUN_O(osc),
    .CPU_RESET_O(cpurst), .BO_LEVEL_HIGH_O(lvl), .IDLE_O(idle), .PDOWN_O(pdn));

  cdpmc_cpu_model i_cpu (.clk_i(clk), .rst_i(rst), .en_i(en), .ack_wait_i(ackw),
    .bo_irq_i(boirq), .gie_o(gie), .bo_ie_o(boie), .ack_o(ack));

  always #5 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask

  // Zero-wait slave still gets a polled access phase
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  // Cycles between two pulses of the probed enable
  task automatic per();
    int i;
    i = 0;
    n = 0;
    @(posedge clk);
    while (probe !== 1'b1 && i < 2000) begin
      @(posedge clk);
      i++;
    end
    do begin
      @(posedge clk);
      n++;
    end while (probe !== 1'b1 && n < 2000);
  endtask

  task automatic t_regs();
    apb(0, A_POWER_CONTROL, 8'h00);
    chk(rd, 32'h30, "power_control after reset");
    apb(1, A_POWER_CONTROL, 8'h0c);
    apb(0, A_POWER_CONTROL, 8'h00);
    chk(rd, 32'h0c, "gp bits kept, flags cleared");
    pwron <= 1'b1;
    @(posedge clk);
    pwron <= 1'b0;
    apb(0, A_POWER_CONTROL, 8'h00);
    chk(rd, 32'h3c, "power-on flags");
    apb(0, 12'h004, 8'h00);
    chk(er, 1, "unmapped error");
    chk(rd, 0, "unmapped data");
    apb(0, 12'h21d, 8'h00);
    chk(er, 1, "misaligned error");
    chk(rd, 0, "misaligned data");
    apb(1, A_POWER_CONTROL, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_clk();
    logic [7:0] nv [3];
    int ev [3];
    nv = '{8'h01, 8'h03, 8'hff};
    ev = '{4, 8, 512};
    per();
    chk(n, 1, "ratio div 0");
    mc <= 1'b1;
    per();
    chk(n, 6, "machine cycle");
    mc <= 1'b0;
    compat <= 1'b1;
    per();
    per();
    chk(n, 2, "halved ratio");
    mc <= 1'b1;
    per();
    per();
    chk(n, 12, "halved machine cycle");
    mc <= 1'b0;
    compat <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      apb(1, A_CPU_CLOCK_DIVIDER, nv[k]);
      per();
      per();
      chk(n, ev[k], "divided ratio");
      chk(cpurst, 0, "no reset on change");
    end
    apb(1, A_CPU_CLOCK_DIVIDER, 8'h01);
    per();
    chk(n >= 4, 1, "no runt after change");
    apb(1, A_CPU_CLOCK_DIVIDER, 8'h00);
    $display("test clock done");
  endtask

  task automatic t_bo();
    apb(1, A_POWER_CONTROL, 8'h00);
    bodet <= 1'b1;
    tick(3);
    chk(cpurst, 1, "brownout reset");
    tick(6);
    chk(cpurst, 1, "reset held");
    bodet <= 1'b0;
    tick(3);
    chk(cpurst, 0, "reset released");
    apb(0, A_POWER_CONTROL, 8'h00);
    chk(rd, 32'h20, "flag after reset");
    apb(1, A_AUX, 8'h20);
    apb(1, A_POWER_CONTROL, 8'h00);
    ackw <= 8'h04;
    bodet <= 1'b1;
    tick(4);
    chk(boirq, 0, "masked request");
    chk(cpurst, 0, "no reset in irq mode");
    en <= 1'b1;
    @(posedge clk);
    chk(boirq, 1, "request pending");
    tick(12);
    chk(boirq, 0, "raised once");
    bodet <= 1'b0;
    apb(0, A_POWER_CONTROL, 8'h00);
    chk(rd, 32'h20, "flag after irq");
    apb(1, A_AUX, 8'h40);
    apb(1, A_POWER_CONTROL, 8'h00);
    bodet <= 1'b1;
    tick(4);
    chk(cpurst, 0, "disabled no reset");
    chk(boirq, 0, "disabled no irq");
    bodet <= 1'b0;
    apb(0, A_POWER_CONTROL, 8'h00);
    chk(rd, 0, "disabled no flag");
    apb(1, A_AUX, 8'h00);
    en <= 1'b0;
    $display("test brownout done");
  endtask

  task automatic t_idle();
    int c, p;
    c = 0;
    p = 0;
    apb(1, A_POWER_CONTROL, 8'h01);
    chk(idle, 1, "idle entered");
    repeat (12) begin
      @(posedge clk);
      c += (cpuen === 1'b1);
      p += (peren === 1'b1);
    end
    chk(c, 0, "cpu stopped");
    chk(p, 12, "peripherals run");
    pend <= 1'b1;
    tick(2);
    chk(idle, 0, "idle ended");
    pend <= 1'b0;
    apb(0, A_POWER_CONTROL, 8'h00);
    chk(rd, 0, "idle bit cleared");
    $display("test idle done");
  endtask

  task automatic t_pdown();
    int cnt;
    for (int k = 0; k < 2; k++) begin
      cnt = (k == 0) ? LONG : SHORT;
      xtal <= (k == 0);
      apb(1, A_POWER_CONTROL, 8'h02);
      chk(pdn, 1, "power-down entered");
      chk(osc, 0, "oscillator stopped");
      tick(5);
      chk(pdn, 1, "stays down without wake");
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      @(posedge clk);
      chk(osc, 1, "oscillator restarted");
      n = 2;
      while (cpuen !== 1'b1 && n < 100) begin
        @(posedge clk);
        n++;
      end
      chk(n >= cnt && n <= cnt + 6, 1, "start-up count");
      apb(0, A_POWER_CONTROL, 8'h00);
      chk(rd, 0, "pd bit cleared");
    end
    apb(1, A_POWER_CONTROL, 8'h02);
    wdt <= 1'b1;
    tick(2);
    wdt <= 1'b0;
    chk(cpurst, 1, "watchdog reset in power-down");
    tick(40);
    chk(pdn, 0, "reset ends power-down");
    apb(0, A_POWER_CONTROL, 8'h00);
    chk(rd, 0, "pd bit cleared by reset");
    apb(1, A_AUX, 8'h20);
    en <= 1'b1;
    apb(1, A_POWER_CONTROL, 8'h02);
    bodet <= 1'b1;
    tick(3);
    chk(pdn, 0, "brownout irq wakes");
    chk(cpurst, 0, "no reset on irq wake");
    bodet <= 1'b0;
    tick(40);
    en <= 1'b0;
    apb(1, A_AUX, 8'h00);
    $display("test power-down done");
  endtask

  task automatic t_misc();
    brownout_level_select <= 1'b0;
    tick(2);
    chk(lvl, 1, "high threshold");
    brownout_level_select <= 1'b1;
    tick(2);
    chk(lvl, 0, "low threshold");
    apb(1, A_POWER_CONTROL, 8'h80);
    chk(baud, 1, "baud double");
    apb(1, A_SERIAL_CONTROL, 8'h80);
    chk(smode, 1, "mode bit stored");
    apb(1, A_POWER_CONTROL, 8'h40);
    chk(sbs, 1, "serial select");
    apb(1, A_SERIAL_CONTROL, 8'h00);
    chk(smode, 1, "bit 7 is framing flag");
    apb(0, A_SERIAL_CONTROL, 8'h00);
    chk(rd, 0, "bit 7 reads framing flag");
    $display("test misc done");
  endtask

  task automatic print_verdict();
    $display("counts: mismatches %0d, comparisons %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    {clk, psel, pen, pwr, compat, pwron, bodet, wdt, pend, wake, en, mc} = '0;
    {rst, brownout_level_select, xtal} = 3'b111;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    ackw = 8'h00;
    err_total = 0;
    samples_checked = 0;
    tick(8);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_clk();
    t_bo();
    t_idle();
    t_pdown();
    t_misc();
    print_verdict();
  end

  // Whole run needs a few thousand cycles
  initial begin
    tick(20000);
    err_total++;
    print_verdict();
  end
endmodule
`default_nettype wire
